/* File: logic/uec_consts.vh */
// Constants for the endpoint control and status block.
// Assumes inclusion by the APB slave and endpoint control files of the block; definitions only.
`ifndef UEC_CONSTS_VH
`define UEC_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define UEC_IDX_SEL        10'h0c7
`define UEC_IDX_STA        10'h0ce
`define UEC_IDX_CFG        10'h0d4

// Endpoint count and highest legal selector value
`define UEC_EP_COUNT       7
`define UEC_EP_MAX         4'h6

// Configuration register fields
`define UEC_CFG_ON         7
`define UEC_CFG_NAKIRQ     6
`define UEC_CFG_NAK_ON_OUT_FLAG     5
`define UEC_CFG_NAK_ON_IN_FLAG      4
`define UEC_CFG_TOGGLE     3
`define UEC_CFG_ORIENT     2
`define UEC_CFG_RST_EP0    8'h80
`define UEC_CFG_RST        8'h00

// Transfer kinds
`define UEC_KIND_CTRL      2'h0
`define UEC_KIND_ISO       2'h1
`define UEC_KIND_BULK      2'h2
`define UEC_KIND_INTR      2'h3

// Status register fields
`define UEC_STA_CTLDIR     7
`define UEC_STA_OUTB1      6
`define UEC_STA_HALTRQ     5
`define UEC_STA_INRDY      4
`define UEC_STA_HALTCRC    3
`define UEC_STA_SETUP      2
`define UEC_STA_OUTB0      1
`define UEC_STA_INDONE     0
`define UEC_STA_RST        8'h00
`define UEC_STA_AFTER_SETUP 8'h04

`endif

/* File: logic/uec_sync.v */
// Two-stage synchroniser for one level.
// Assumes the input is asynchronous to pclk; only the second stage is read.
module uec_sync (
	input  wire pclk,
	input  wire presetn,
	input  wire ce,
	input  wire async_in,
	output reg  sync_q
);
	reg meta_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (ce) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule

/* File: logic/uec_apb_slave.v */
// APB slave front end: one wait-free access phase, decode and error answer.
// Assumes the parent supplies read data for the decoded register in setup.
`include "uec_consts.vh"

module uec_apb_slave (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [7:0]  rd_data,
	output reg         pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	output wire        dec_sel,
	output wire        dec_sta,
	output wire        dec_cfg,
	output wire        wr_sel,
	output wire        wr_sta,
	output wire        wr_cfg,
	output wire [7:0]  wr_data
);
	wire aligned;
	wire hit;
	wire commit;

	assign aligned = (paddr[1:0] == 2'h0);
	assign dec_sel = aligned && (paddr[11:2] == `UEC_IDX_SEL);
	assign dec_sta = aligned && (paddr[11:2] == `UEC_IDX_STA);
	assign dec_cfg = aligned && (paddr[11:2] == `UEC_IDX_CFG);
	assign hit     = dec_sel || dec_sta || dec_cfg;
	// Writes land only on the edge that closes the access phase
	assign commit  = psel && penable && pready && pwrite && hit;
	assign wr_sel  = commit && dec_sel;
	assign wr_sta  = commit && dec_sta;
	assign wr_cfg  = commit && dec_cfg;
	assign wr_data = pwdata[7:0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			if (psel && !penable) begin
				pready  <= 1'b1;
				pslverr <= !hit;
				prdata  <= (hit && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

/* File: logic/uec_endpoint_ctrl.v */
// Endpoint configuration and handshake flags for seven USB endpoints.
// Assumes the USB packet engine runs on pclk and reports events as pulses;
// the bus reset level comes from the line detector, outside this clock domain.
//
// Function
// R1 - Configuration bit 7 enables the endpoint; endpoint 0 comes up enabled.
// R2 - Configuration bit 6 gates both NAK flags onto the endpoint interrupt.
// R3 - NAK sent to an OUT sets configuration bit 5 until software clears it.
// R4 - NAK sent to an IN sets configuration bit 4 until software clears it.
// R5 - Read-only bit 3 sets on accepted DATA0, clears on accepted DATA1.
// R6 - Bit 2 selects IN when set, OUT when clear; ignored on control endpoints.
// R7 - Kind field: 00 control, 01 isochronous, 10 bulk, 11 interrupt; endpoint 0 control.
// R8 - Configuration resets to 80h on endpoint 0 and 00h elsewhere.
// R9 - Firmware sets status bit 7 only for a control IN data stage.
// R10 - Bank 1 full sets status bit 6, interrupts, NAKs bank 1 unless isochronous.
// R11 - Status bit 5 requests STALL; a valid SETUP clears it on control endpoints.
// R12 - Firmware sets status bit 4 after loading the FIFO; empty means zero length.
// R13 - Hardware clears bit 4 when sent (isochronous) or acknowledged; interrupts.
// R14 - Non-isochronous: bit 3 sets after a requested STALL went out; interrupts.
// R15 - Isochronous: bit 3 is read-only CRC error of the latest data packet.
// R16 - Valid SETUP sets bit 2, clears all other status bits, interrupts.
// R17 - Bank 0 full sets status bit 1, interrupts, NAKs bank 0 unless isochronous.
// R18 - On control endpoints SETUP is taken even while bank 0 is full.
// R19 - Bit 0 sets when an IN packet went out or was acknowledged; interrupts. Isochronous sets it on sent only, others on acknowledged only.
// R20 - Firmware clears bit 0 before setting bit 4 again.
// R21 - A four-bit selector, legal values 0 to 6, picks the endpoint addressed.
// R22 - Writing zero clears a hardware flag; a same-cycle hardware set wins.
`include "uec_consts.vh"

module uec_endpoint_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire [31:0] prdata,
	output wire        pslverr,
	input  wire        usb_bus_reset,
	input  wire        ev_valid,
	input  wire [3:0]  ev_ep,
	input  wire        ev_setup,
	input  wire        ev_out_bank0,
	input  wire        ev_out_bank1,
	input  wire        ev_nak_out,
	input  wire        ev_nak_in,
	input  wire        ev_in_sent,
	input  wire        ev_in_ack,
	input  wire        ev_stall_sent,
	input  wire        ev_rx_pkt,
	input  wire        ev_rx_data1,
	input  wire        ev_rx_accept,
	input  wire        ev_rx_crc_bad,
	output reg  [6:0]  ep_on_q,
	output reg  [6:0]  ep_iso_q,
	output reg  [6:0]  ep_in_dir_q,
	output reg  [6:0]  ep_ctl_in_q,
	output reg  [6:0]  ep_halt_q,
	output reg  [6:0]  ep_in_ready_q,
	output reg  [6:0]  ep_nak_b0_q,
	output reg  [6:0]  ep_nak_b1_q,
	output reg  [6:0]  ep_irq_q
);
	localparam NEP = `UEC_EP_COUNT;

	// Per-endpoint register file, one byte lane per endpoint
	reg  [8*NEP-1:0] cfg_q;
	reg  [8*NEP-1:0] cfg_d;
	reg  [8*NEP-1:0] sta_q;
	reg  [8*NEP-1:0] sta_d;
	reg  [3:0]       sel_q;
	reg  [3:0]       sel_d;

	// Derived per-endpoint views, registered onto the outputs
	reg  [6:0]       on_d;
	reg  [6:0]       iso_d;
	reg  [6:0]       in_dir_d;
	reg  [6:0]       ctl_in_d;
	reg  [6:0]       halt_d;
	reg  [6:0]       in_ready_d;
	reg  [6:0]       nak_b0_d;
	reg  [6:0]       nak_b1_d;
	reg  [6:0]       irq_d;

	// Loop scratch
	reg  [7:0]       c;
	reg  [7:0]       s;
	reg              iso;
	reg              ctl;
	reg              hit;
	reg              sw_cfg;
	reg              sw_sta;
	reg              in_done;
	integer          i;

	wire             bus_rst;
	wire             dec_sel;
	wire             dec_sta;
	wire             dec_cfg;
	wire             wr_sel;
	wire             wr_sta;
	wire             wr_cfg;
	wire [7:0]       wr_data;
	reg  [7:0]       rd_data;
	wire             sel_legal;

	uec_sync u_bus_rst_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.async_in (usb_bus_reset),
		.sync_q   (bus_rst)
	);

	uec_apb_slave u_apb (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.rd_data  (rd_data),
		.pready   (pready),
		.prdata   (prdata),
		.pslverr  (pslverr),
		.dec_sel  (dec_sel),
		.dec_sta  (dec_sta),
		.dec_cfg  (dec_cfg),
		.wr_sel   (wr_sel),
		.wr_sta   (wr_sta),
		.wr_cfg   (wr_cfg),
		.wr_data  (wr_data)
	);

	// Selector outside 0..6 addresses nothing: reads zero, writes dropped
	assign sel_legal = (sel_q <= `UEC_EP_MAX); // see R21

	always @* begin
		rd_data = 8'h00;
		if (dec_sel) begin
			rd_data = {4'h0, sel_q};
		end else if (dec_sta && sel_legal) begin
			rd_data = sta_q[sel_q*8 +: 8]; // see R21
		end else if (dec_cfg && sel_legal) begin
			rd_data = cfg_q[sel_q*8 +: 8];
		end
	end

	always @* begin
		sel_d      = wr_sel ? wr_data[3:0] : sel_q;
		cfg_d      = cfg_q;
		sta_d      = sta_q;
		on_d       = 7'h00;
		iso_d      = 7'h00;
		in_dir_d   = 7'h00;
		ctl_in_d   = 7'h00;
		halt_d     = 7'h00;
		in_ready_d = 7'h00;
		nak_b0_d   = 7'h00;
		nak_b1_d   = 7'h00;
		irq_d      = 7'h00;
		c          = 8'h00;
		s          = 8'h00;
		iso        = 1'b0;
		ctl        = 1'b0;
		hit        = 1'b0;
		sw_cfg     = 1'b0;
		sw_sta     = 1'b0;
		in_done    = 1'b0;
		for (i = 0; i < NEP; i = i + 1) begin
			c      = cfg_q[i*8 +: 8];
			s      = sta_q[i*8 +: 8];
			iso    = (c[1:0] == `UEC_KIND_ISO);
			ctl    = (c[1:0] == `UEC_KIND_CTRL);
			hit    = ev_valid && (ev_ep == i[3:0]);
			sw_cfg = wr_cfg && (sel_q == i[3:0]); // see R21
			sw_sta = wr_sta && (sel_q == i[3:0]);

			// Software writes first, so hardware events below override them
			if (sw_cfg) begin
				c[`UEC_CFG_ON]     = wr_data[`UEC_CFG_ON]; // see R1
				c[`UEC_CFG_NAKIRQ] = wr_data[`UEC_CFG_NAKIRQ];
				c[`UEC_CFG_NAK_ON_OUT_FLAG] = c[`UEC_CFG_NAK_ON_OUT_FLAG] & wr_data[`UEC_CFG_NAK_ON_OUT_FLAG]; // see R22
				c[`UEC_CFG_NAK_ON_IN_FLAG]  = c[`UEC_CFG_NAK_ON_IN_FLAG] & wr_data[`UEC_CFG_NAK_ON_IN_FLAG]; // see R22
				c[`UEC_CFG_ORIENT] = wr_data[`UEC_CFG_ORIENT];
				// Endpoint 0 keeps the control kind whatever is written
				c[1:0] = (i == 0) ? `UEC_KIND_CTRL : wr_data[1:0]; // see R7
			end
			if (sw_sta) begin
				s[`UEC_STA_CTLDIR] = wr_data[`UEC_STA_CTLDIR]; // see R9
				s[`UEC_STA_OUTB1]  = s[`UEC_STA_OUTB1] & wr_data[`UEC_STA_OUTB1]; // see R22
				s[`UEC_STA_HALTRQ] = wr_data[`UEC_STA_HALTRQ];
				s[`UEC_STA_INRDY]  = wr_data[`UEC_STA_INRDY]; // see R12
				if (!iso) begin
					s[`UEC_STA_HALTCRC] = s[`UEC_STA_HALTCRC] & wr_data[`UEC_STA_HALTCRC];
				end
				s[`UEC_STA_SETUP]  = s[`UEC_STA_SETUP] & wr_data[`UEC_STA_SETUP];
				s[`UEC_STA_OUTB0]  = s[`UEC_STA_OUTB0] & wr_data[`UEC_STA_OUTB0];
				s[`UEC_STA_INDONE] = s[`UEC_STA_INDONE] & wr_data[`UEC_STA_INDONE];
			end

			if (hit) begin
				if (ev_nak_out) begin
					c[`UEC_CFG_NAK_ON_OUT_FLAG] = 1'b1; // see R3
				end
				if (ev_nak_in) begin
					c[`UEC_CFG_NAK_ON_IN_FLAG] = 1'b1; // see R4
				end
				if (ev_rx_pkt && ev_rx_accept) begin
					c[`UEC_CFG_TOGGLE] = !ev_rx_data1; // see R5
				end
				if (ev_rx_pkt && iso) begin
					s[`UEC_STA_HALTCRC] = ev_rx_crc_bad; // see R15
				end
				if (ev_stall_sent && !iso) begin
					s[`UEC_STA_HALTCRC] = 1'b1; // see R14
				end
				if (ev_out_bank0) begin
					s[`UEC_STA_OUTB0] = 1'b1; // see R17
				end
				if (ev_out_bank1) begin
					s[`UEC_STA_OUTB1] = 1'b1; // see R10
				end
				// Isochronous completes on transmit, the rest on the host ACK
				in_done = iso ? ev_in_sent : ev_in_ack;
				if (in_done) begin
					s[`UEC_STA_INRDY]  = 1'b0; // see R13
					s[`UEC_STA_INDONE] = 1'b1; // see R19
				end
				// SETUP wins over every other status event and ignores a full bank 0; bus reset below still wins
				if (ev_setup && ctl) begin
					s = `UEC_STA_AFTER_SETUP; // see R16 R11 R18
				end
			end

			if (bus_rst) begin
				c = (i == 0) ? `UEC_CFG_RST_EP0 : `UEC_CFG_RST; // see R8 R1
				s = `UEC_STA_RST;
			end

			cfg_d[i*8 +: 8] = c;
			sta_d[i*8 +: 8] = s;

			iso           = (c[1:0] == `UEC_KIND_ISO);
			ctl           = (c[1:0] == `UEC_KIND_CTRL);
			on_d[i]       = c[`UEC_CFG_ON]; // see R1
			iso_d[i]      = iso;
			in_dir_d[i]   = c[`UEC_CFG_ORIENT] && !ctl; // see R6
			ctl_in_d[i]   = s[`UEC_STA_CTLDIR] && ctl;
			halt_d[i]     = s[`UEC_STA_HALTRQ]; // see R11
			in_ready_d[i] = s[`UEC_STA_INRDY];
			// Isochronous endpoints never refuse data on a full bank
			nak_b0_d[i]   = s[`UEC_STA_OUTB0] && !iso; // see R17
			nak_b1_d[i]   = s[`UEC_STA_OUTB1] && !iso; // see R10
			irq_d[i]      = s[`UEC_STA_OUTB1] | s[`UEC_STA_SETUP] | s[`UEC_STA_OUTB0]
				| s[`UEC_STA_INDONE] | (s[`UEC_STA_HALTCRC] & !iso)
				| (c[`UEC_CFG_NAKIRQ] & (c[`UEC_CFG_NAK_ON_OUT_FLAG] | c[`UEC_CFG_NAK_ON_IN_FLAG])); // see R2
		end
		if (bus_rst) begin
			sel_d = 4'h0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q         <= 4'h0;
			cfg_q         <= {{(8*(NEP-1)){1'b0}}, `UEC_CFG_RST_EP0}; // see R8
			sta_q         <= {(8*NEP){1'b0}};
			ep_on_q       <= 7'h01;
			ep_iso_q      <= 7'h00;
			ep_in_dir_q   <= 7'h00;
			ep_ctl_in_q   <= 7'h00;
			ep_halt_q     <= 7'h00;
			ep_in_ready_q <= 7'h00;
			ep_nak_b0_q   <= 7'h00;
			ep_nak_b1_q   <= 7'h00;
			ep_irq_q      <= 7'h00;
		end else if (ce) begin
			sel_q         <= sel_d;
			cfg_q         <= cfg_d;
			sta_q         <= sta_d;
			ep_on_q       <= on_d;
			ep_iso_q      <= iso_d;
			ep_in_dir_q   <= in_dir_d;
			ep_ctl_in_q   <= ctl_in_d;
			ep_halt_q     <= halt_d;
			ep_in_ready_q <= in_ready_d;
			ep_nak_b0_q   <= nak_b0_d;
			ep_nak_b1_q   <= nak_b1_d;
			ep_irq_q      <= irq_d;
		end
	end
endmodule

/* File: testbench/uec_host_model.sv */
// Packet engine stand-in: reports USB events per endpoint as one-cycle pulses.
// Assumes the caller enters pulse just after a rising edge of pclk.
module uec_host_model (
	input  wire         pclk,
	output logic        ev_valid,
	output logic [3:0]  ev_ep,
	output logic [11:0] ev
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ev_valid = 1'h0;
		ev_ep = 4'hf;
		ev = 12'h0;
	end
	// Outside a pulse the qualifiers flip, so stale values are never mistaken for live ones
	task automatic pulse(input logic [3:0] ep, input logic [11:0] m);
		@(posedge pclk);
		ev_valid <= 1'h1;
		ev_ep <= ep;
		ev <= m;
		@(posedge pclk);
		ev_valid <= 1'h0;
		ev_ep <= ~ep;
		ev <= {~m[11:9], 9'h0};
	endtask
endmodule

/* File: testbench/uec_endpoint_ctrl_monitor.sv */
// Checker for the bus answer and endpoint flag behaviour.
// Assumes binding to uec_endpoint_ctrl; it watches that module's ports only.
module uec_endpoint_ctrl_monitor (
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire        pready,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire        ev_valid,
	input wire [3:0]  ev_ep,
	input wire        ev_setup,
	input wire        ev_out_bank0,
	input wire        ev_in_ack,
	input wire [6:0]  ep_on_q,
	input wire [6:0]  ep_iso_q,
	input wire [6:0]  ep_in_dir_q,
	input wire [6:0]  ep_halt_q,
	input wire [6:0]  ep_in_ready_q,
	input wire [6:0]  ep_nak_b0_q,
	input wire [6:0]  ep_irq_q
);
	timeunit 1ns;
	timeprecision 1ns;
	wire stp = psel && !penable && ce;
	wire ev = ev_valid && ce && ev_ep < 4'h7;
	wire map = paddr == 12'h31c || paddr == 12'h338 || paddr == 12'h350;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_single: assert property (stp |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	a_map_error: assert property (pready && !map |-> pslverr)
		else $error("unmapped access not refused");
	a_map_ok: assert property (pready && map |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access refused or wide");
	a_reset_ep0_on: assert property ($rose(presetn) |-> ep_on_q == 7'h01 && ep_irq_q == 7'h0)
		else $error("reset state wrong");
	a_ep0_control: assert property (!ep_iso_q[0] && !ep_in_dir_q[0])
		else $error("endpoint 0 not control");
	a_bank0_nak: assert property (ev && ev_out_bank0 && !ev_setup && !ep_iso_q[ev_ep]
		|=> ep_nak_b0_q[$past(ev_ep)] && ep_irq_q[$past(ev_ep)])
		else $error("bank 0 full not flagged");
	a_iso_no_nak: assert property ((ep_nak_b0_q & ep_iso_q) == 7'h0)
		else $error("isochronous endpoint refuses OUT");
	a_in_done: assert property (ev && ev_in_ack && !ev_setup && !ep_iso_q[ev_ep]
		|=> !ep_in_ready_q[$past(ev_ep)] && ep_irq_q[$past(ev_ep)])
		else $error("IN acknowledge not handled");
	a_setup_clears: assert property (ev && ev_setup && ev_ep == 4'h0
		|=> ep_irq_q[0] && !ep_halt_q[0] && !ep_in_ready_q[0] && !ep_nak_b0_q[0])
		else $error("setup did not clear status");
	c_access: cover property (stp ##1 pready);
	c_error: cover property (pready && pslverr);
	c_setup: cover property (ev && ev_setup);
endmodule

bind uec_endpoint_ctrl uec_endpoint_ctrl_monitor uec_endpoint_ctrl_monitor_inst (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.ev_valid(ev_valid), .ev_ep(ev_ep), .ev_setup(ev_setup), .ev_out_bank0(ev_out_bank0),
	.ev_in_ack(ev_in_ack), .ep_on_q(ep_on_q), .ep_iso_q(ep_iso_q), .ep_in_dir_q(ep_in_dir_q),
	.ep_halt_q(ep_halt_q), .ep_in_ready_q(ep_in_ready_q), .ep_nak_b0_q(ep_nak_b0_q),
	.ep_irq_q(ep_irq_q));

/* File: testbench/usb_endpoint_control_status_tb.sv */
// Self-checking bench: firmware speaks APB, the packet engine model raises events.
// Assumes a 50 MHz pclk; ce stays high, so clock gating is not exercised.
`include "uec_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module usb_endpoint_control_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] SEL = {`UEC_IDX_SEL, 2'h0};
	localparam logic [11:0] STA = {`UEC_IDX_STA, 2'h0};
	localparam logic [11:0] CFG = {`UEC_IDX_CFG, 2'h0};
	logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, usb_bus_reset = 1'h0, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	wire pready, pslverr, ev_valid;
	wire [31:0] prdata;
	wire [3:0] ev_ep;
	wire [11:0] ev;
	wire [6:0] ep_on_q, ep_iso_q, ep_in_dir_q, ep_ctl_in_q, ep_halt_q;
	wire [6:0] ep_in_ready_q, ep_nak_b0_q, ep_nak_b1_q, ep_irq_q;
	int n_errors = 0, tests_run = 0;
	always #10 pclk = ~pclk;
	uec_host_model uec_host_model_inst (.pclk(pclk), .ev_valid(ev_valid), .ev_ep(ev_ep), .ev(ev));
	uec_endpoint_ctrl uec_endpoint_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset),
		.ev_valid(ev_valid), .ev_ep(ev_ep), .ev_setup(ev[0]), .ev_out_bank0(ev[1]),
		.ev_out_bank1(ev[2]), .ev_nak_out(ev[3]), .ev_nak_in(ev[4]), .ev_in_sent(ev[5]),
		.ev_in_ack(ev[6]), .ev_stall_sent(ev[7]), .ev_rx_pkt(ev[8]), .ev_rx_data1(ev[9]),
		.ev_rx_accept(ev[10]), .ev_rx_crc_bad(ev[11]), .ep_on_q(ep_on_q), .ep_iso_q(ep_iso_q),
		.ep_in_dir_q(ep_in_dir_q), .ep_ctl_in_q(ep_ctl_in_q), .ep_halt_q(ep_halt_q),
		.ep_in_ready_q(ep_in_ready_q), .ep_nak_b0_q(ep_nak_b0_q), .ep_nak_b1_q(ep_nak_b1_q),
		.ep_irq_q(ep_irq_q));
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Waits on pready itself, so a slower slave would still be served
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h0);
		`CHK($sformatf("reg %h", a), {24'h0, e, 1'h0}, {rd, er})
	endtask
	task automatic hit(input logic [3:0] ep, input logic [11:0] m);
		uec_host_model_inst.pulse(ep, m);
		// Flag outputs settle after the taking edge; look at them half a cycle on
		@(negedge pclk);
	endtask
	initial begin
		#50000;
		n_errors++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		rc(CFG, 8'h80);
		rc(STA, 8'h00);
		for (int i = 1; i < 7; i++) begin
			wr(SEL, i[7:0]);
			rc(CFG, 8'h00);
		end
		wr(SEL, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(CFG, 8'h84 | k[7:0]);
			rc(CFG, 8'h84 | k[7:0]);
			`CHK("iso", k == 1, ep_iso_q[1])
			`CHK("dir", k != 0, ep_in_dir_q[1])
		end
		wr(SEL, 8'h00);
		wr(CFG, 8'h83);
		rc(CFG, 8'h80);
		wr(SEL, 8'h01);
		wr(CFG, 8'h83);
		hit(4'h1, 12'h008);
		rc(CFG, 8'ha3);
		`CHK("irq", 1'h0, ep_irq_q[1])
		wr(CFG, 8'he3);
		hit(4'h1, 12'h010);
		rc(CFG, 8'hf3);
		`CHK("irq", 1'h1, ep_irq_q[1])
		wr(CFG, 8'hc3);
		rc(CFG, 8'hc3);
		hit(4'h1, 12'h500);
		rc(CFG, 8'hcb);
		hit(4'h1, 12'h300);
		rc(CFG, 8'hcb);
		hit(4'h1, 12'h700);
		rc(CFG, 8'hc3);
		hit(4'h1, 12'h002);
		rc(STA, 8'h02);
		`CHK("nak0", 1'h1, ep_nak_b0_q[1])
		hit(4'h1, 12'h004);
		rc(STA, 8'h42);
		`CHK("nak1", 1'h1, ep_nak_b1_q[1])
		wr(STA, 8'h40);
		rc(STA, 8'h40);
		wr(STA, 8'h10);
		hit(4'h1, 12'h020);
		rc(STA, 8'h10);
		hit(4'h1, 12'h040);
		rc(STA, 8'h01);
		`CHK("irq", 1'h1, ep_irq_q[1])
		wr(CFG, 8'h81);
		wr(STA, 8'h10);
		hit(4'h1, 12'h040);
		rc(STA, 8'h10);
		hit(4'h1, 12'h020);
		rc(STA, 8'h01);
		hit(4'h1, 12'h080);
		rc(STA, 8'h01);
		hit(4'h1, 12'h900);
		wr(STA, 8'h00);
		rc(STA, 8'h08);
		hit(4'h1, 12'h002);
		`CHK("nak0", 1'h0, ep_nak_b0_q[1])
		hit(4'h1, 12'h100);
		rc(STA, 8'h02);
		wr(CFG, 8'h82);
		wr(STA, 8'h20);
		hit(4'h1, 12'h080);
		rc(STA, 8'h28);
		hit(4'h1, 12'h001);
		rc(STA, 8'h28);
		wr(SEL, 8'h00);
		wr(STA, 8'hb0);
		rc(STA, 8'hb0);
		`CHK("ep0", 3'h7, {ep_ctl_in_q[0], ep_halt_q[0], ep_in_ready_q[0]})
		hit(4'h0, 12'h002);
		hit(4'h0, 12'h001);
		rc(STA, 8'h04);
		`CHK("irq", 1'h1, ep_irq_q[0])
		`CHK("ep0", 3'h0, {ep_ctl_in_q[0], ep_halt_q[0], ep_in_ready_q[0]})
		wr(SEL, 8'h07);
		wr(CFG, 8'h80);
		rc(CFG, 8'h00);
		apb(1'h0, 12'h339, 8'h0);
		`CHK("err", 1'h1, er)
		wr(SEL, 8'h01);
		usb_bus_reset <= 1'h1;
		repeat (4) @(posedge pclk);
		usb_bus_reset <= 1'h0;
		repeat (4) @(posedge pclk);
		rc(SEL, 8'h00);
		rc(CFG, 8'h80);
		`CHK("on", 7'h01, ep_on_q)
		close_out;
	end
endmodule
